// file: rtl/csf_cfg.svh
// constants for the client signal fail framer: pdu fields, codes and timing
// assumes inclusion by the monitor, the top level and any other design file that needs a figure
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH

// ***************************************************************
// pdu header fields
// ***************************************************************
`define CSF_VERSION        5'h00
`define CSF_OPCODE         8'h34
`define CSF_TLV_OFFSET     8'h00
`define CSF_END_TLV        8'h00
`define CSF_DROP_ELIGIBLE  1'h0

// ***************************************************************
// flag field positions and codes
// ***************************************************************
`define CSF_TYPE_MSB       6
`define CSF_TYPE_LSB       4
`define CSF_PERIOD_MSB     3
`define CSF_PERIOD_LSB     1
`define CSF_TYPE_LOS       3'h0
`define CSF_TYPE_FDI       3'h1
`define CSF_TYPE_RDI       3'h2
`define CSF_TYPE_DCI       3'h3
`define CSF_PERIOD_INVALID 3'h0
`define CSF_PERIOD_1S      3'h4
`define CSF_PERIOD_1MIN    3'h6

// ***************************************************************
// timing: base tick is half a second, periods counted in ticks
// ***************************************************************
`define CSF_CLOCK_NS       25
`define CSF_TICK_MS        500
`define CSF_HALVES_1S      9'h002
`define CSF_HALVES_1MIN    9'h078
`define CSF_TIMEOUT_TENTHS 32'h23
`define CSF_TENTHS_DIV     32'h0A

`endif

// file: rtl/csf_pkg.sv
// types shared by the client signal fail framer and its receive monitor
// assumes csf_cfg.svh holds every figure
`default_nettype none

package csf_pkg;

   // transmit sequencer
   typedef enum logic {TX_IDLE, TX_SENDING} tx_state_type;

   // all transmit side state
   typedef struct packed {
      tx_state_type state;
      logic [31:0]  divCount;
      logic         halfTick;
      logic [8:0]   periodCount;
      logic         cfgEnable;
      logic         cfgMinute;
      logic         txValid;
      logic [2:0]   txLevel;
      logic [4:0]   txVersion;
      logic [7:0]   txOpcode;
      logic [7:0]   txFlags;
      logic [7:0]   txTlvOffset;
      logic [7:0]   txEndTlv;
      logic [2:0]   txPriority;
      logic         txDropEligible;
   } tx_regs_type;

   // all receive side state
   typedef struct packed {
      logic       remoteCsf;
      logic       egressDown;
      logic [8:0] waitCount;
      logic [8:0] waitLimit;
      logic       discard;
      logic       forward;
   } rx_regs_type;

endpackage

`default_nettype wire

// file: rtl/csf_rx_if.sv
// carrier between the framer top and its receive monitor
// assumes one clock domain; no clocking block
`timescale 1ns/100ps
`default_nettype none

interface csf_rx_if;
   logic       frameValid;   // received pdu strobe
   logic [2:0] frameLevel;   // received level
   logic [4:0] frameVersion; // received version
   logic [7:0] frameOpcode;  // received opcode
   logic [7:0] frameFlags;   // received flags
   logic [2:0] localLevel;   // configured level
   logic       halfTick;     // half second enable
   logic       ccmLoss;      // remote end point lost continuity
   logic       enabled;      // end point fit for csf
   logic       mipMode;      // intermediate point
   logic       remoteCsf;    // remote condition
   logic       egressDown;   // egress port forced down
   logic       discard;      // pdu dropped
   logic       forward;      // pdu passed through

   modport top (output frameValid, frameLevel, frameVersion, frameOpcode, frameFlags,
                output localLevel, halfTick, ccmLoss, enabled, mipMode,
                input remoteCsf, egressDown, discard, forward);
   modport mon (input frameValid, frameLevel, frameVersion, frameOpcode, frameFlags,
                input localLevel, halfTick, ccmLoss, enabled, mipMode,
                output remoteCsf, egressDown, discard, forward);
endinterface

`default_nettype wire

// file: rtl/csf_rx_monitor.sv
// receive side of the client signal fail framer: remote condition and egress port
// assumes pdu fields are presented in parallel with a one-cycle strobe
`timescale 1ns/100ps
`default_nettype none
`include "csf_cfg.svh"

module csf_rx_monitor (
   input  wire logic clock,  // 40 MHz clock
   input  wire logic rst_n,  // async reset, active low
   csf_rx_if.mon     rx      // frame in, condition out
);

   csf_pkg::rx_regs_type r;
   csf_pkg::rx_regs_type next_r;

   logic       isCsf;
   logic [2:0] rxType;
   logic [2:0] rxPeriod;
   logic       periodOk;
   logic       accepted;
   logic [8:0] rxHalves;

   // ***************************************************************
   // frame classification
   // ***************************************************************
   assign isCsf    = rx.frameValid && rx.frameOpcode == `CSF_OPCODE;
   assign rxType   = rx.frameFlags[`CSF_TYPE_MSB:`CSF_TYPE_LSB];
   assign rxPeriod = rx.frameFlags[`CSF_PERIOD_MSB:`CSF_PERIOD_LSB];
   assign periodOk = rxPeriod == `CSF_PERIOD_1S || rxPeriod == `CSF_PERIOD_1MIN;
   assign accepted = isCsf && rx.enabled && !rx.mipMode && periodOk
                     && rx.frameVersion == `CSF_VERSION && rx.frameLevel == rx.localLevel;
   assign rxHalves = (rxPeriod == `CSF_PERIOD_1MIN) ? `CSF_HALVES_1MIN : `CSF_HALVES_1S;

   // next state; continuity loss outranks a frame in the same cycle
   always_comb begin
      next_r         = r;
      next_r.discard = isCsf && !rx.mipMode && !accepted;
      next_r.forward = isCsf && rx.mipMode;
      if (rx.ccmLoss || !rx.enabled) begin
         next_r.remoteCsf = 1'b0;
      end else if (accepted) begin
         next_r.remoteCsf = rxType != `CSF_TYPE_DCI;
         next_r.waitCount = 9'h000;
         next_r.waitLimit = 9'((32'(rxHalves) * `CSF_TIMEOUT_TENTHS) / `CSF_TENTHS_DIV);
      end else if (r.remoteCsf && rx.halfTick) begin
         next_r.waitCount = r.waitCount + 9'h001;
         if (r.waitCount + 9'h001 >= r.waitLimit) begin
            next_r.remoteCsf = 1'b0;
         end
      end
      next_r.egressDown = r.remoteCsf;
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rx.remoteCsf  = r.remoteCsf;
   assign rx.egressDown = r.egressDown;
   assign rx.discard    = r.discard;
   assign rx.forward    = r.forward;

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence s_declare;
      accepted && rxType != `CSF_TYPE_DCI && !rx.ccmLoss;
   endsequence

   property p_declare;
      @(posedge clock) disable iff (!rst_n) s_declare |=> r.remoteCsf ##1 r.egressDown;
   endproperty
   a_declare: assert property (p_declare) else $error("csf pdu did not down the port");

   property p_clear_dci;
      @(posedge clock) disable iff (!rst_n)
         accepted && rxType == `CSF_TYPE_DCI |=> !r.remoteCsf ##1 !r.egressDown;
   endproperty
   a_clear_dci: assert property (p_clear_dci) else $error("clear pdu ignored");

   property p_ccm_loss;
      @(posedge clock) disable iff (!rst_n) rx.ccmLoss |=> !r.remoteCsf ##1 !r.egressDown;
   endproperty
   a_ccm_loss: assert property (p_ccm_loss) else $error("port held down on ccm loss");

   property p_bad_level;
      @(posedge clock) disable iff (!rst_n)
         isCsf && rx.frameLevel != rx.localLevel && !rx.ccmLoss && !rx.halfTick
         |=> r.remoteCsf == $past(r.remoteCsf) && r.discard == !$past(rx.mipMode);
   endproperty
   a_bad_level: assert property (p_bad_level) else $error("wrong level pdu acted on");

endmodule

`default_nettype wire

// file: rtl/client_signal_fail_oam.sv
// client signal fail framer for a down maintenance end point, top level
// assumes an outer frame builder takes the parallel pdu fields on txValid
// assumes received pdus arrive parsed, one strobe per pdu, synchronous to clock
`timescale 1ns/100ps
`default_nettype none
`include "csf_cfg.svh"

module client_signal_fail_oam #(
   parameter int unsigned HALF_SEC_CYCLES = `CSF_TICK_MS * 1000000 / `CSF_CLOCK_NS
) (
   input  wire logic       clock,          // 40 MHz clock
   input  wire logic       rst_n,          // async reset, active low
   // end point configuration and state
   input  wire logic       csfTxEnable,    // transmission enable
   input  wire logic       txPeriodMinute, // 1: one minute period, 0: one second
   input  wire logic [2:0] csfType,        // defect type to report
   input  wire logic       clearByPdu,     // 1: send clear pdu, 0: fall silent
   input  wire logic [2:0] localLevel,     // maintenance level
   input  wire logic [2:0] csfPriority,    // priority of csf frames
   input  wire logic       mepIsDown,      // end point faces down
   input  wire logic       mepIsP2p,       // point-to-point association
   input  wire logic       mepIsMip,       // intermediate point
   input  wire logic       mepOperUp,      // end point up, not failed
   input  wire logic       ccmLoss,        // remote end point lost continuity
   input  wire logic       clientBound,    // one client interface bound
   input  wire logic       clientIsLagMember, // bound port sits in an aggregate
   input  wire logic       clientFault,    // ingress client port fault
   // transmit pdu
   output logic            txValid,        // one-cycle pdu request
   output logic [2:0]      txLevel,        // level field
   output logic [4:0]      txVersion,      // version field
   output logic [7:0]      txOpcode,       // opcode field
   output logic [7:0]      txFlags,        // flags field
   output logic [7:0]      txTlvOffset,    // tlv offset field
   output logic [7:0]      txEndTlv,       // end tlv octet
   output logic [2:0]      txPriority,     // frame priority
   output logic            txDropEligible, // drop eligible mark
   // receive pdu
   input  wire logic       rxValid,        // one-cycle pdu strobe
   input  wire logic [2:0] rxLevel,        // level field
   input  wire logic [4:0] rxVersion,      // version field
   input  wire logic [7:0] rxOpcode,       // opcode field
   input  wire logic [7:0] rxFlags,        // flags field
   // results
   output logic            remoteCsf,      // remote condition declared
   output logic            egressPortDown, // egress client port forced down
   output logic            rxDiscard,      // pdu dropped, one cycle
   output logic            rxForward       // pdu passed through, one cycle
);

   // ***************************************************************
   // constants and state
   // ***************************************************************
   localparam logic [31:0] HALF_LAST = 32'(HALF_SEC_CYCLES - 1);

   csf_pkg::tx_regs_type r;
   csf_pkg::tx_regs_type next_r;

   logic       mepFit;
   logic       clientOk;
   logic       txAllowed;
   logic [8:0] periodHalves;
   logic [2:0] periodCode;

   csf_rx_if rxBus ();

   assign mepFit = mepIsDown && mepIsP2p && !mepIsMip;
   assign clientOk = clientBound && !clientIsLagMember;
   assign txAllowed = r.cfgEnable && mepFit && clientOk && mepOperUp;

   assign periodCode   = r.cfgMinute ? `CSF_PERIOD_1MIN : `CSF_PERIOD_1S;
   assign periodHalves = r.cfgMinute ? `CSF_HALVES_1MIN : `CSF_HALVES_1S;

   // ***************************************************************
   // transmit sequencer and half second divider
   // ***************************************************************
   // one process fills every field; constant fields are rewritten each cycle so a
   // glitch on the state register cannot leave a wrong header latched
   always_comb begin
      next_r          = r;
      next_r.txValid  = 1'b0;
      next_r.halfTick = 1'b0;
      next_r.cfgEnable = csfTxEnable;
      next_r.cfgMinute = txPeriodMinute;
      next_r.txVersion = `CSF_VERSION;
      next_r.txOpcode  = `CSF_OPCODE;
      next_r.txTlvOffset = `CSF_TLV_OFFSET;
      next_r.txEndTlv    = `CSF_END_TLV;
      next_r.txDropEligible = `CSF_DROP_ELIGIBLE;

      // free running divider gives a one-cycle tick every half second
      if (r.divCount >= HALF_LAST) begin
         next_r.divCount = 32'h0000_0000;
         next_r.halfTick = 1'b1;
      end else begin
         next_r.divCount = r.divCount + 32'h0000_0001;
      end

      unique case (r.state)
         csf_pkg::TX_IDLE: begin
            next_r.periodCount = 9'h000;
            if (txAllowed && clientFault) begin
               next_r.txValid = 1'b1;
               next_r.state   = csf_pkg::TX_SENDING;
               next_r.txFlags = {1'b0, csfType, periodCode, 1'b0};
            end
         end
         csf_pkg::TX_SENDING: begin
            if (!txAllowed) begin
               next_r.state = csf_pkg::TX_IDLE;
            end else if (!clientFault) begin
               next_r.state = csf_pkg::TX_IDLE;
               if (clearByPdu) begin
                  next_r.txValid = 1'b1;
                  next_r.txFlags = {1'b0, `CSF_TYPE_DCI, periodCode, 1'b0};
               end
            end else if (r.halfTick) begin
               if (r.periodCount + 9'h001 >= periodHalves) begin
                  next_r.periodCount = 9'h000;
                  next_r.txValid     = 1'b1;
                  next_r.txFlags     = {1'b0, csfType, periodCode, 1'b0};
               end else begin
                  next_r.periodCount = r.periodCount + 9'h001;
               end
            end
         end
      endcase

      if (next_r.txValid) begin
         next_r.txLevel    = localLevel;
         next_r.txPriority = csfPriority;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r                <= '0;
         r.state          <= csf_pkg::TX_IDLE;
         r.txVersion      <= `CSF_VERSION;
         r.txOpcode       <= `CSF_OPCODE;
         r.txTlvOffset    <= `CSF_TLV_OFFSET;
         r.txEndTlv       <= `CSF_END_TLV;
         r.txDropEligible <= `CSF_DROP_ELIGIBLE;
      end else begin
         r <= next_r;
      end
   end

   assign txValid        = r.txValid;
   assign txLevel        = r.txLevel;
   assign txVersion      = r.txVersion;
   assign txOpcode       = r.txOpcode;
   assign txFlags        = r.txFlags;
   assign txTlvOffset    = r.txTlvOffset;
   assign txEndTlv       = r.txEndTlv;
   assign txPriority     = r.txPriority;
   assign txDropEligible = r.txDropEligible;

   // ***************************************************************
   // receive monitor
   // ***************************************************************
   // the monitor shares the divider tick, so the timeout has half second grain
   assign rxBus.frameValid   = rxValid;
   assign rxBus.frameLevel   = rxLevel;
   assign rxBus.frameVersion = rxVersion;
   assign rxBus.frameOpcode  = rxOpcode;
   assign rxBus.frameFlags   = rxFlags;
   assign rxBus.localLevel   = localLevel;
   assign rxBus.halfTick     = r.halfTick;
   assign rxBus.ccmLoss      = ccmLoss;
   assign rxBus.enabled      = mepIsDown && mepIsP2p && clientOk;
   assign rxBus.mipMode      = mepIsMip;

   csf_rx_monitor monitor (
      .clock (clock),
      .rst_n (rst_n),
      .rx    (rxBus)
   );

   assign remoteCsf      = rxBus.remoteCsf;
   assign egressPortDown = rxBus.egressDown;
   assign rxDiscard      = rxBus.discard;
   assign rxForward      = rxBus.forward;

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence s_fault_seen;
      r.state == csf_pkg::TX_IDLE && txAllowed && clientFault;
   endsequence

   sequence s_first_frame;
      r.txValid && r.txFlags[`CSF_TYPE_MSB:`CSF_TYPE_LSB] == $past(csfType);
   endsequence

   property p_start;
      @(posedge clock) disable iff (!rst_n) s_fault_seen |=> s_first_frame;
   endproperty
   a_start: assert property (p_start) else $error("no frame at fault onset");

   property p_needs_fault;
      @(posedge clock) disable iff (!rst_n)
         r.txValid && r.txFlags[`CSF_TYPE_MSB:`CSF_TYPE_LSB] != `CSF_TYPE_DCI
         |-> $past(clientFault);
   endproperty
   a_needs_fault: assert property (p_needs_fault) else $error("frame with no fault");

   property p_enable;
      @(posedge clock) disable iff (!rst_n) r.txValid |-> $past(r.cfgEnable);
   endproperty
   a_enable: assert property (p_enable) else $error("frame while disabled");

   property p_marking;
      @(posedge clock) disable iff (!rst_n)
         r.txValid |-> !r.txDropEligible && r.txPriority == $past(csfPriority);
   endproperty
   a_marking: assert property (p_marking) else $error("bad priority or drop mark");

   property p_oper_down;
      @(posedge clock) disable iff (!rst_n) !mepOperUp |=> !r.txValid;
   endproperty
   a_oper_down: assert property (p_oper_down) else $error("frame from failed end point");

   property p_header;
      @(posedge clock) disable iff (!rst_n)
         r.txValid |-> r.txOpcode == 8'h34 && r.txVersion == 5'h00
                       && r.txLevel == $past(localLevel);
   endproperty
   a_header: assert property (p_header) else $error("bad pdu header");

   property p_period;
      @(posedge clock) disable iff (!rst_n)
         r.txValid |-> r.txFlags[3:1] == ($past(r.cfgMinute) ? 3'h6 : 3'h4)
                       && !r.txFlags[7] && !r.txFlags[0];
   endproperty
   a_period: assert property (p_period) else $error("bad period code");

   property p_tlv;
      @(posedge clock) disable iff (!rst_n) r.txTlvOffset == 8'h00 && r.txEndTlv == 8'h00;
   endproperty
   a_tlv: assert property (p_tlv) else $error("tlv fields not zero");

   property p_clear_pdu;
      @(posedge clock) disable iff (!rst_n)
         r.state == csf_pkg::TX_SENDING && txAllowed && !clientFault && clearByPdu
         |=> r.txValid && r.txFlags[6:4] == 3'h3 ##1 (!r.txValid || $past(clientFault));
   endproperty
   a_clear_pdu: assert property (p_clear_pdu) else $error("no clear pdu");

endmodule

`default_nettype wire

// file: tb/peer_mep.sv
// peer end point model: hands parsed csf pdus to the receive side
// assumes the bench calls send from its own main process
`timescale 1ns/100ps
`default_nettype none

module peer_mep (
   input  wire logic  clock,     // bench clock
   output logic       rxValid,   // pdu strobe
   output logic [2:0] rxLevel,   // level field
   output logic [4:0] rxVersion, // version field
   output logic [7:0] rxOpcode,  // opcode field
   output logic [7:0] rxFlags    // flags field
);
   // idle line before the first pdu
   initial begin
      rxValid = 1'b0;
      {rxLevel, rxVersion, rxOpcode, rxFlags} = 24'h000000;
   end

   // pdu encoding
   // fields are inverted after the strobe so a stale copy never passes
   task automatic send(input logic [2:0] lvl, input logic [2:0] typ, input logic [2:0] per);
      @(negedge clock);
      rxValid   = 1'b1;
      rxLevel   = lvl;
      rxVersion = 5'h00;
      rxOpcode  = 8'h34;
      rxFlags   = {1'b0, typ, per, 1'b0};
      @(negedge clock);
      rxValid = 1'b0;
      {rxLevel, rxVersion, rxOpcode, rxFlags} = ~{rxLevel, rxVersion, rxOpcode, rxFlags};
   endtask
endmodule

`default_nettype wire

// file: tb/client_signal_fail_oam_bench.sv
// self-checking bench for the client signal fail framer
// assumes a half second shrunk to four clocks; the peer model feeds rx pdus
`timescale 1ns/100ps
`default_nettype none

module client_signal_fail_oam_bench;
   localparam int HALF = 4; // short tick keeps timeouts to tens of cycles
   logic       clock, rst_n, csfTxEnable, txPeriodMinute, clearByPdu, mepIsDown;
   logic       mepIsP2p, mepIsMip, mepOperUp, ccmLoss, clientBound, clientIsLagMember;
   logic       clientFault, txValid, txDropEligible, rxValid, remoteCsf, egressPortDown;
   logic       rxDiscard, rxForward, d, f;
   logic [2:0] csfType, localLevel, csfPriority, txLevel, txPriority, rxLevel;
   logic [4:0] txVersion, rxVersion;
   logic [7:0] txOpcode, txFlags, txTlvOffset, txEndTlv, rxOpcode, rxFlags;
   int         fails = 0, n_compared = 0, cycles = 0, t;

   client_signal_fail_oam #(.HALF_SEC_CYCLES(HALF)) dut (.clock, .rst_n, .csfTxEnable,
      .txPeriodMinute, .csfType, .clearByPdu, .localLevel, .csfPriority, .mepIsDown,
      .mepIsP2p, .mepIsMip, .mepOperUp, .ccmLoss, .clientBound, .clientIsLagMember,
      .clientFault, .txValid, .txLevel, .txVersion, .txOpcode, .txFlags, .txTlvOffset,
      .txEndTlv, .txPriority, .txDropEligible, .rxValid, .rxLevel, .rxVersion, .rxOpcode,
      .rxFlags, .remoteCsf, .egressPortDown, .rxDiscard, .rxForward);
   peer_mep peer (.clock, .rxValid, .rxLevel, .rxVersion, .rxOpcode, .rxFlags);

   // ****************************************************
   // clock, hang guard and shared tasks
   // ****************************************************
   initial clock = 1'b0;
   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         conclude();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // cycles until a tx pulse, 0 when none came within the limit
   task automatic waitTx(input int limit, output int took);
      took = 0;
      for (int i = 1; i <= limit && took == 0; i++) begin
         @(posedge clock);
         #1;
         if (txValid === 1'b1) took = i;
      end
   endtask

   // the pulse already stands when the peer returns, so start from it, then collect
   task automatic rxPulses();
      d = rxDiscard;
      f = rxForward;
      repeat (3) begin
         @(posedge clock);
         #1;
         d = d | rxDiscard;
         f = f | rxForward;
      end
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ****************************************************
   // scenarios
   // ****************************************************
   // each of four gates alone (enable, oper up, lag member, facing down) silences a faulty client
   task automatic testGates();
      for (int g = 0; g < 4; g++) begin
         @(negedge clock);
         csfTxEnable = (g != 0);
         mepOperUp = (g != 1);
         clientIsLagMember = (g == 2);
         mepIsDown = (g != 3);
         clientFault = 1'b1;
         waitTx(24, t);
         check("gated tx", t[7:0], 8'h00);
         @(negedge clock);
         clientFault = 1'b0;
         mepIsDown = 1'b1;
         clientIsLagMember = 1'b0;
         mepOperUp = 1'b1;
         repeat (3) @(negedge clock);
      end
   endtask

   task automatic testTx();
      @(negedge clock);
      clientFault = 1'b1;
      waitTx(4, t);
      check("prompt start", t[7:0], 8'h01);
      check("flags", txFlags, 8'h28);
      check("level", {5'h00, txLevel}, 8'h05);
      check("prio drop", {txPriority, txDropEligible}, 8'h0C);
      check("version", {3'h0, txVersion}, 8'h00);
      check("opcode", txOpcode, 8'h34);
      check("tlv", txTlvOffset | txEndTlv, 8'h00);
      waitTx(10, t);
      waitTx(10, t);
      check("frame gap", t[7:0], 8'(2 * HALF));
      @(negedge clock);
      clientFault = 1'b0;
      waitTx(4, t);
      check("clear pdu", txFlags, 8'h38);
      waitTx(24, t);
      check("quiet", t[7:0], 8'h00);
      @(negedge clock);
      txPeriodMinute = 1'b1;
      csfType = 3'h0;
      clearByPdu = 1'b0;
      repeat (2) @(negedge clock);
      clientFault = 1'b1;
      waitTx(4, t);
      check("minute flags", txFlags, 8'h0C);
      @(negedge clock);
      clientFault = 1'b0;
      waitTx(24, t);
      check("silent clear", t[7:0], 8'h00);
   endtask

   task automatic testRx();
      peer.send(3'h5, 3'h0, 3'h4);
      repeat (2) @(posedge clock);
      #1;
      check("declare", {remoteCsf, egressPortDown}, 8'h03);
      peer.send(3'h5, 3'h3, 3'h4);
      repeat (2) @(posedge clock);
      #1;
      check("dci clear", {remoteCsf, egressPortDown}, 8'h00);
      peer.send(3'h5, 3'h1, 3'h4);
      repeat (20) @(posedge clock);
      #1;
      check("held", {7'h00, remoteCsf}, 8'h01);
      repeat (12) @(posedge clock);
      #1;
      check("timed out", {remoteCsf, egressPortDown}, 8'h00);
      // level mismatch, invalid period, reserved period
      for (int b = 0; b < 3; b++) begin
         peer.send((b == 0) ? 3'h4 : 3'h5, 3'h0, (b == 0) ? 3'h4 : (b == 1) ? 3'h0 : 3'h5);
         rxPulses();
         check("discard", {6'h00, d, remoteCsf}, 8'h02);
      end
      peer.send(3'h5, 3'h2, 3'h4);
      @(negedge clock);
      check("ccm pre", {7'h00, remoteCsf}, 8'h01);
      ccmLoss = 1'b1;
      repeat (2) @(negedge clock);
      check("ccm loss", {remoteCsf, egressPortDown}, 8'h00);
      ccmLoss = 1'b0;
      mepIsMip = 1'b1;
      peer.send(3'h5, 3'h0, 3'h4);
      rxPulses();
      check("mip pass", {6'h00, f, remoteCsf}, 8'h02);
      @(negedge clock);
      mepIsMip = 1'b0;
   endtask

   // ****************************************************
   // main sequence
   // ****************************************************
   initial begin
      {rst_n, csfTxEnable, txPeriodMinute, mepIsMip, ccmLoss, clientIsLagMember} = 6'h00;
      {clearByPdu, mepIsDown, mepIsP2p, mepOperUp, clientBound} = 5'h1F;
      clientFault = 1'b0;
      csfType = 3'h2;
      localLevel = 3'h5;
      csfPriority = 3'h6;
      repeat (12) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      #1;
      check("reset", {txValid, remoteCsf, egressPortDown, txDropEligible}, 8'h00);
      testGates();
      testTx();
      testRx();
      conclude();
   end
endmodule

`default_nettype wire
